//--- core/ssr_regs.svh
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define SSR_OFS_CTRL 8'h00
`define SSR_OFS_STATUS 8'h04
`define SSR_OFS_CLEAR 8'h08
`define SSR_OFS_ENABLE 8'h0C
`define SSR_OFS_SUPPLY 8'h10

// ****************************************
// Control fields
// ****************************************
`define SSR_CTRL_DET_EN 0
`define SSR_CTRL_LVL_LO 1
`define SSR_CTRL_LVL_HI 3
`define SSR_CTRL_FALL_EN 4
`define SSR_CTRL_RISE_EN 5
`define SSR_CTRL_HALT_OFF 6
`define SSR_CTRL_RESET 8'h00

// ****************************************
// Status fields
// ****************************************
`define SSR_ST_FALL 0
`define SSR_ST_RISE 1

// ****************************************
// Option byte fields and levels
// ****************************************
`define SSR_OPT_LVL_LO 0
`define SSR_OPT_LVL_HI 2
`define SSR_OPT_DIS 3
`define SSR_BOR_LVL_DEFAULT 3'h0
`define SSR_BOR_LVL_MAX 3'h4
`define SSR_DET_LVL_MAX 3'h6
`define SSR_DET_LVL_RESET 3'h0

// ****************************************
// Timing
// ****************************************
`define SSR_CLK_MHZ 125
`define SSR_SETTLE_NS 80
`define SSR_SETTLE_CYC ((`SSR_SETTLE_NS * `SSR_CLK_MHZ + 999) / 1000)

`endif

//--- core/ssr_pkg.sv
package ssr_pkg;

    typedef enum logic [1:0] {
        SSR_ST_RESET = 2'b00,
        SSR_ST_LOAD = 2'b01,
        SSR_ST_SETTLE = 2'b10,
        SSR_ST_RUN = 2'b11
    } ssr_state_e;

    typedef struct packed {
        logic halt_off;
        logic rise_en;
        logic fall_en;
        logic [2:0] level;
        logic det_en;
    } ssr_ctrl_s;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [31:0] wdata;
    } ssr_bus_s;

endpackage

//--- core/ssr_supply_supervisor.sv
`include "ssr_regs.svh"

module ssr_supply_supervisor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Strap: brownout-disable ordering variant
    input wire logic variant_bor_disabled,
    // Analog comparators, active high when supply is above threshold
    input wire logic por_above,
    input wire logic bor_min_above,
    input wire logic bor_sel_above,
    input wire logic det_above,
    // Option byte store
    input wire logic opt_valid,
    input wire logic [7:0] opt_data,
    output logic opt_req,
    // Analog controls
    output logic [2:0] brownout_threshold_level,
    output logic brownout_enable,
    output logic reference_enable,
    output logic [2:0] detector_threshold_level,
    output logic detector_enable,
    // Power mode
    input wire logic halt_mode,
    // System reset and interrupt
    output logic system_reset,
    output logic irq,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata
);

    // ****************************************
    // State
    // ****************************************
    ssr_pkg::ssr_state_e state;
    ssr_pkg::ssr_state_e next_state;
    ssr_pkg::ssr_ctrl_s ctrl;
    ssr_pkg::ssr_ctrl_s next_ctrl;
    ssr_pkg::ssr_bus_s bus;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] next_sync1;
    logic [3:0] next_sync2;
    logic det_prev;
    logic next_det_prev;
    logic det_armed;
    logic next_det_armed;
    logic [2:0] bor_level;
    logic [2:0] next_bor_level;
    logic bor_off;
    logic next_bor_off;
    logic [7:0] settle;
    logic [7:0] next_settle;
    logic [1:0] status;
    logic [1:0] next_status;
    logic [1:0] irq_en;
    logic [1:0] next_irq_en;
    logic [31:0] next_rdata;
    logic next_opt_req;
    logic next_system_reset;
    logic next_irq;
    logic next_bor_en_out;
    logic next_ref_en;
    logic next_det_en_out;
    logic [2:0] next_det_lvl_out;
    logic [2:0] next_bor_lvl_out;
    logic por_ok;
    logic min_ok;
    logic sel_ok;
    logic det_ok;
    logic gated;
    logic [1:0] events;
    logic [2:0] opt_lvl;

    assign bus = '{write: reg_write, read: reg_read, addr: reg_addr, wdata: reg_wdata};
    assign por_ok = sync2[0];
    assign min_ok = sync2[1];
    assign sel_ok = sync2[2];
    assign det_ok = sync2[3];

    // ****************************************
    // Synchronizers
    // ****************************************
    always_comb begin
        next_sync1 = {det_above, bor_sel_above, bor_min_above, por_above};
        next_sync2 = sync1;
    end

    // ****************************************
    // Power-up sequencing
    // ****************************************
    always_comb begin
        next_state = state;
        next_bor_level = bor_level;
        next_bor_off = bor_off;
        next_settle = settle;
        next_opt_req = 1'b0;
        opt_lvl = opt_data[`SSR_OPT_LVL_HI:`SSR_OPT_LVL_LO];
        gated = ctrl.halt_off && halt_mode;
        case (state)
            ssr_pkg::SSR_ST_RESET: begin
                next_bor_level = `SSR_BOR_LVL_DEFAULT;
                next_bor_off = variant_bor_disabled;
                if (por_ok && (min_ok || variant_bor_disabled)) begin
                    next_state = ssr_pkg::SSR_ST_LOAD;
                end
            end
            ssr_pkg::SSR_ST_LOAD: begin
                next_opt_req = 1'b1;
                if (opt_valid) begin
                    next_opt_req = 1'b0;
                    if (opt_data[`SSR_OPT_DIS] || variant_bor_disabled) begin
                        next_bor_off = 1'b1;
                    end else if (opt_lvl <= `SSR_BOR_LVL_MAX) begin
                        next_bor_level = opt_lvl;
                    end
                    next_settle = 8'(`SSR_SETTLE_CYC);
                    next_state = ssr_pkg::SSR_ST_SETTLE;
                end
            end
            ssr_pkg::SSR_ST_SETTLE: begin
                if (settle <= 8'h01) begin
                    next_state = ssr_pkg::SSR_ST_RUN;
                end else begin
                    next_settle = settle - 8'h01;
                end
            end
            ssr_pkg::SSR_ST_RUN: begin
                if (!bor_off && !gated && !sel_ok) begin
                    next_state = ssr_pkg::SSR_ST_SETTLE;
                    next_settle = 8'(`SSR_SETTLE_CYC);
                end
            end
            default: begin
                next_state = ssr_pkg::SSR_ST_RESET;
            end
        endcase
        if (!por_ok) begin
            next_state = ssr_pkg::SSR_ST_RESET;
        end
        next_system_reset = (next_state != ssr_pkg::SSR_ST_RUN);
        next_bor_en_out = !next_bor_off && !gated;
        next_ref_en = !gated;
        next_bor_lvl_out = next_bor_level;
    end

    // ****************************************
    // Voltage detector and interrupts
    // ****************************************
    always_comb begin
        next_det_prev = det_ok;
        next_det_armed = ctrl.det_en && (state == ssr_pkg::SSR_ST_RUN);
        events = 2'b00;
        if (det_armed && ctrl.det_en) begin
            events[`SSR_ST_FALL] = ctrl.fall_en && det_prev && !det_ok;
            events[`SSR_ST_RISE] = ctrl.rise_en && !det_prev && det_ok;
        end
        next_ctrl = ctrl;
        next_irq_en = irq_en;
        next_status = status;
        if (bus.write && bus.addr == `SSR_OFS_CTRL) begin
            next_ctrl = ssr_pkg::ssr_ctrl_s'(bus.wdata[6:0]);
            if (bus.wdata[`SSR_CTRL_LVL_HI:`SSR_CTRL_LVL_LO] > `SSR_DET_LVL_MAX) begin
                next_ctrl.level = `SSR_DET_LVL_MAX;
            end
        end
        if (bus.write && bus.addr == `SSR_OFS_ENABLE) begin
            next_irq_en = bus.wdata[1:0];
        end
        if (bus.write && bus.addr == `SSR_OFS_CLEAR) begin
            next_status = status & ~bus.wdata[1:0];
        end
        next_status = next_status | events;
        next_irq = |(next_status & next_irq_en);
        next_det_en_out = next_ctrl.det_en;
        next_det_lvl_out = next_ctrl.level;
        next_rdata = 32'h00000000;
        if (bus.read) begin
            case (bus.addr)
                `SSR_OFS_CTRL: next_rdata = {25'h0000000, ctrl};
                `SSR_OFS_STATUS: next_rdata = {30'h00000000, status};
                `SSR_OFS_ENABLE: next_rdata = {30'h00000000, irq_en};
                `SSR_OFS_SUPPLY: next_rdata = {22'h000000, bor_off, bor_level,
                                               state, sync2};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            state <= ssr_pkg::SSR_ST_RESET;
            bor_level <= `SSR_BOR_LVL_DEFAULT;
            bor_off <= 1'b0;
            settle <= 8'h00;
            opt_req <= 1'b0;
            system_reset <= 1'b1;
            brownout_enable <= 1'b1;
            reference_enable <= 1'b1;
            brownout_threshold_level <= `SSR_BOR_LVL_DEFAULT;
            ctrl <= ssr_pkg::ssr_ctrl_s'(`SSR_CTRL_RESET);
            irq_en <= 2'h0;
            status <= 2'h0;
            det_prev <= 1'b0;
            det_armed <= 1'b0;
            irq <= 1'b0;
            detector_enable <= 1'b0;
            detector_threshold_level <= `SSR_DET_LVL_RESET;
            reg_rdata <= 32'h00000000;
        end else if (clk_en) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            state <= next_state;
            bor_level <= next_bor_level;
            bor_off <= next_bor_off;
            settle <= next_settle;
            opt_req <= next_opt_req;
            system_reset <= next_system_reset;
            brownout_enable <= next_bor_en_out;
            reference_enable <= next_ref_en;
            brownout_threshold_level <= next_bor_lvl_out;
            ctrl <= next_ctrl;
            irq_en <= next_irq_en;
            status <= next_status;
            det_prev <= next_det_prev;
            det_armed <= next_det_armed;
            irq <= next_irq;
            detector_enable <= next_det_en_out;
            detector_threshold_level <= next_det_lvl_out;
            reg_rdata <= next_rdata;
        end
    end

endmodule

//--- verif/ssr_chk.sv
`include "ssr_regs.svh"

// ****
// Port checks
// ****
module ssr_chk (
    // Clock
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // Supply side
    input wire logic variant_bor_disabled,
    input wire logic por_above,
    input wire logic opt_valid,
    input wire logic [7:0] opt_data,
    input wire logic opt_req,
    // Outputs
    input wire logic [2:0] brownout_threshold_level,
    input wire logic brownout_enable,
    input wire logic reference_enable,
    input wire logic [2:0] detector_threshold_level,
    input wire logic system_reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence opt_taken_s;
        opt_req && opt_valid && clk_en;
    endsequence
    sequence por_low_s;
        (!por_above && clk_en)[*6];
    endsequence
    load_hold_a: assert property (opt_req |-> system_reset) else
        $error("reset released while loading");
    settle_hold_a: assert property (opt_taken_s |=> system_reset[*8]) else
        $error("reset released too early");
    por_reset_a: assert property (por_low_s |-> system_reset) else
        $error("no reset under low supply");
    sync_delay_a: assert property ($fell(por_above) && !system_reset |=> !system_reset) else
        $error("comparator not synchronized");
    variant_off_a: assert property (variant_bor_disabled && !system_reset |-> !brownout_enable)
        else $error("brownout on in variant");
    halt_gate_a: assert property (!reference_enable |-> !brownout_enable) else
        $error("brownout on without reference");
    bor_range_a: assert property (brownout_threshold_level <= 3'h4) else
        $error("brownout level out of range");
    opt_level_a: assert property (opt_taken_s and (opt_data[2:0] <= 3'h4 && !opt_data[3]
        && !variant_bor_disabled) |=>
        brownout_threshold_level == $past(opt_data[2:0])) else
        $error("option level not applied");
    det_level_a: assert property (reg_write && clk_en && reg_addr == `SSR_OFS_CTRL |=>
        detector_threshold_level == ($past(reg_wdata[3:1]) > 3'h6 ? 3'h6 : $past(reg_wdata[3:1])))
        else $error("detector level wrong");
endmodule

bind ssr_supply_supervisor ssr_chk chk_u (.clk, .reset, .clk_en, .variant_bor_disabled,
    .por_above, .opt_valid, .opt_data, .opt_req, .brownout_threshold_level,
    .brownout_enable, .reference_enable, .detector_threshold_level, .system_reset,
    .reg_addr, .reg_wdata, .reg_write);

//--- verif/ssr_supply_model.sv
// ****
// Comparators and option store
// ****
module ssr_supply_model #(parameter int POR_MV = 1500) (
    // Bench controls
    input wire logic clk,
    input wire logic [15:0] vdd_mv,
    input wire logic [7:0] opt_byte,
    input wire logic [7:0] opt_wait,
    // Device side
    input wire logic opt_req,
    input wire logic [2:0] brownout_threshold_level,
    input wire logic [2:0] detector_threshold_level,
    output logic por_above,
    output logic bor_min_above,
    output logic bor_sel_above,
    output logic det_above,
    output logic opt_valid,
    output logic [7:0] opt_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    assign por_above = vdd_mv > POR_MV;
    assign bor_min_above = vdd_mv >= 1800;
    assign bor_sel_above = vdd_mv >= 1800 + 300 * brownout_threshold_level;
    assign det_above = vdd_mv >= 1850 + 200 * detector_threshold_level;
    assign opt_data = opt_valid ? opt_byte : ~opt_byte;
    always @(posedge clk) begin
        cnt <= (opt_req && !opt_valid) ? cnt + 1 : 0;
        opt_valid <= opt_req && !opt_valid && cnt >= opt_wait;
    end
endmodule

//--- verif/ssr_supply_supervisor_tb_top.sv
`include "ssr_regs.svh"

module ssr_supply_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1, halt_mode = 1'b0;
    logic variant_bor_disabled = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00, opt_byte = 8'h00, opt_wait = 8'h03;
    logic [31:0] reg_wdata = 32'h0;
    logic [15:0] vdd_mv = 1700;
    logic por_above, bor_min_above, bor_sel_above, det_above, opt_valid, opt_req;
    logic brownout_enable, reference_enable, detector_enable, system_reset, irq;
    logic [7:0] opt_data;
    logic [2:0] brownout_threshold_level, detector_threshold_level;
    logic [31:0] reg_rdata;
    logic [15:0] rows [8] = '{16'h0000, 16'h0303, 16'h0505, 16'h0707, 16'h0909, 16'h0B0B,
        16'h0D0D, 16'hFF7D};
    int n_mismatch = 0;
    int n_tests = 0;

    ssr_supply_supervisor dut_u (.clk, .reset, .clk_en, .variant_bor_disabled, .por_above,
        .bor_min_above, .bor_sel_above, .det_above, .opt_valid, .opt_data, .opt_req,
        .brownout_threshold_level, .brownout_enable, .reference_enable,
        .detector_threshold_level, .detector_enable, .halt_mode, .system_reset, .irq,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
    ssr_supply_model model_u (.clk, .vdd_mv, .opt_byte, .opt_wait, .opt_req,
        .brownout_threshold_level, .detector_threshold_level, .por_above, .bor_min_above,
        .bor_sel_above, .det_above, .opt_valid, .opt_data);

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic wait_rst(input logic v);
        for (int k = 0; k < 300 && system_reset !== v; k++) begin
            @(posedge clk);
        end
    endtask
    task automatic boot(input logic vb, input logic [7:0] ob);
        reset <= 1'b1;
        variant_bor_disabled <= vb;
        opt_byte <= ob;
        opt_wait <= {5'h00, ob[2:0]};
        vdd_mv <= 3300;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        wait_rst(1'b0);
        chk("reset_release", system_reset, 1'b0);
    endtask
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test;
    end
    initial begin
        logic [31:0] d;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (30) @(posedge clk);
        chk("opt_req", opt_req, 1'b0);
        chk("low_reset", system_reset, 1'b1);
        chk("bor_en", brownout_enable, 1'b1);
        chk("irq", irq, 1'b0);
        boot(1'b0, 8'h07);
        chk("bor_lvl", brownout_threshold_level, 3'h0);
        boot(1'b0, 8'h08);
        chk("bor_off", brownout_enable, 1'b0);
        boot(1'b1, 8'h02);
        chk("variant_off", brownout_enable, 1'b0);
        boot(1'b0, 8'h04);
        chk("bor_lvl", brownout_threshold_level, 3'h4);
        boot(1'b0, 8'h01);
        chk("bor_lvl", brownout_threshold_level, 3'h1);
        chk("bor_en", brownout_enable, 1'b1);
        vdd_mv <= 2000;
        wait_rst(1'b1);
        chk("bor_trip", system_reset, 1'b1);
        vdd_mv <= 3300;
        wait_rst(1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(`SSR_OFS_CTRL, {24'h0, rows[i][15:8]});
            rd(`SSR_OFS_CTRL, d);
            chk("ctrl", d, {24'h0, rows[i][7:0]});
            chk("det_lvl", detector_threshold_level, rows[i][3:1]);
            chk("det_en", detector_enable, rows[i][0]);
        end
        wr(`SSR_OFS_ENABLE, 32'h3);
        for (int i = 1; i < 4; i++) begin
            wr(`SSR_OFS_CTRL, 32'h07 | (i << 4));
            wr(`SSR_OFS_CLEAR, 32'h3);
            vdd_mv <= 2300;
            repeat (8) @(posedge clk);
            chk("irq_fall", irq, i[0]);
            vdd_mv <= 3300;
            repeat (8) @(posedge clk);
            rd(`SSR_OFS_STATUS, d);
            chk("status", d, i);
        end
        wr(`SSR_OFS_ENABLE, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq_mask", irq, 1'b0);
        wr(`SSR_OFS_CLEAR, 32'h3);
        wr(`SSR_OFS_CTRL, 32'h36);
        vdd_mv <= 2300;
        repeat (8) @(posedge clk);
        rd(`SSR_OFS_STATUS, d);
        chk("status_off", d, 32'h0);
        rd(8'h20, d);
        chk("unmapped", d, 32'h0);
        wr(`SSR_OFS_CTRL, 32'h40);
        halt_mode <= 1'b1;
        repeat (4) @(posedge clk);
        chk("ref_halt", reference_enable, 1'b0);
        chk("bor_halt", brownout_enable, 1'b0);
        halt_mode <= 1'b0;
        repeat (4) @(posedge clk);
        chk("ref_wake", reference_enable, 1'b1);
        chk("bor_wake", brownout_enable, 1'b1);
        end_of_test;
    end
endmodule
